// ---- src/can_message_buffer_store.sv ----
// Functional notes
// RULE1 - All buffers share one 13-byte layout, undefined
// RULE2 - Receive buffer read-only; transmit buffers read-write
// RULE3 - Extended identifier bit placement across four bytes
// RULE4 - Standard identifier in bytes 0-1, extension cleared
// RULE5 - 11 or 29 bit identifiers, MSB first
// RULE6 - Smallest identifier value has highest priority
// RULE7 - Substitute remote bit: set by software, stored received
// RULE8 - Extension flag selects format, set on receive
// RULE9 - Remote flag stored on receive, drives transmit
// RULE10 - Remote frame sends length code, no data
// RULE11 - Length code low nibble, counts 0 to 8
// RULE12 - Eight payload bytes; only counted ones used
// RULE13 - Local priority byte only for transmit buffers
// RULE14 - Arbitrate queued buffers just before start of frame
// RULE15 - Smallest local priority wins; ties lower index
// RULE16 - Software never writes a queued transmit buffer
// RULE17 - Software reads receive buffer only when full
// RULE18 - Control register 0 layout and reset values
// RULE19 - Wait-stop bit stops module clock in wait
// RULE20 - Buffers at blocks 4,5,6,7 of 16 bytes
// RULE21 - Soft reset aborts, holds control and flags
// RULE22 - Resync after 11 recessive bits, 128 if bus-off
// RULE23 - Sleep acknowledge set only while asleep
// RULE24 - Synced status shows bus participation
// RULE25 - Software clears empty flag; sent frame sets it
// RULE26 - Length codes above eight count as eight
`timescale 1ns/1ps
`include "msg_store_regs.svh"

module can_message_buffer_store (
	input  wire logic            clock_in,
	input  wire logic            arst_n_in,
	input  wire logic [8:0]      reg_addr_in,
	input  wire logic            reg_wr_in,
	input  wire logic            reg_rd_in,
	input  wire logic [7:0]      reg_wdata_in,
	output logic      [7:0]      reg_rdata_out,
	input  wire logic [2:0]      tx_queue_in,
	output logic      [2:0]      tx_empty_flag_out,
	input  wire logic            rx_release_in,
	output logic                 rx_full_flag_out,
	input  wire logic            tx_sof_req_in,
	input  wire logic            tx_done_in,
	output logic                 tx_valid_out,
	output logic      [1:0]      tx_buffer_sel_out,
	output logic      [28:0]     tx_id_out,
	output logic                 tx_ext_out,
	output logic                 tx_srr_out,
	output logic                 tx_rtr_out,
	output logic      [3:0]      tx_length_code_out,
	output logic      [3:0]      tx_byte_count_out,
	output logic      [7:0][7:0] tx_data_out,
	input  wire logic            rx_store_in,
	input  wire logic [28:0]     rx_id_in,
	input  wire logic            rx_ext_in,
	input  wire logic            rx_srr_in,
	input  wire logic            rx_rtr_in,
	input  wire logic [3:0]      rx_length_code_in,
	input  wire logic [7:0][7:0] rx_data_in,
	input  wire logic            bit_tick_in,
	input  wire logic            bus_recessive_in,
	input  wire logic            bus_off_in,
	input  wire logic            bus_active_in,
	input  wire logic            wait_mode_in,
	output logic                 module_clock_run_out,
	output logic                 timer_link_out,
	output logic                 soft_reset_out,
	output logic                 bus_synced_status_out,
	output logic                 sleep_acknowledge_out
);

	msg_store_pkg::state_t st_reg;
	msg_store_pkg::state_t st_next;

	// Identifier bytes to a right-aligned identifier value
	function automatic logic [28:0] id_decode(input logic [3:0][7:0] idb, input logic ext);
		if (ext) begin
			id_decode = {idb[0], idb[1][7:5], idb[1][2:0], idb[2], idb[3][7:1]};    // [RULE3]
		end else begin
			id_decode = {18'h0_0000, idb[0], idb[1][7:5]};                          // [RULE4]
		end
	endfunction

	function automatic logic [3:0] byte_count(input logic [3:0] code, input logic remote_frame_flag);
		if (remote_frame_flag) begin
			byte_count = 4'h0;                                                       // [RULE10]
		end else if (code > `MAX_DATA_BYTES) begin
			byte_count = `MAX_DATA_BYTES;                                            // [RULE26]
		end else begin
			byte_count = code;                                                       // [RULE11]
		end
	endfunction

	// Returns {found, index}; strict compare keeps the lower index on ties
	function automatic logic [2:0] pick_winner(input logic [2:0][7:0] prio,
			input logic [2:0] empty);
		logic       found;
		logic [1:0] idx;
		logic [7:0] best;
		found = 1'b0;
		idx   = 2'h0;
		best  = 8'hFF;
		for (int i = 0; i < 3; i++) begin
			if (!empty[i] && (!found || prio[i] < best)) begin                  // [RULE15]
				found = 1'b1;
				idx   = 2'(i);
				best  = prio[i];
			end
		end
		pick_winner = {found, idx};
	endfunction

	logic [1:0] acc_buf;
	logic [3:0] acc_ofs;
	logic       acc_region;
	logic [2:0] winner;
	logic [3:0] rx_count;

	assign acc_buf    = reg_addr_in[5:4];
	assign acc_ofs    = reg_addr_in[3:0];
	assign acc_region = reg_addr_in[8:6] == `BUF_REGION;                           // [RULE20]
	assign winner     = pick_winner(st_reg.prio, st_reg.tx_empty);
	assign rx_count   = byte_count(rx_length_code_in, rx_rtr_in);

	always_comb begin
		st_next = st_reg;
		st_next.rdata = 8'h00;

		// Register reads; unmapped and unused locations return zero
		if (reg_rd_in) begin
			if (reg_addr_in == `CTRL0_ADDR) begin
				st_next.rdata = {2'b00, st_reg.wait_stop, st_reg.sync == msg_store_pkg::SYNC_ON,
					st_reg.timer_link, st_reg.sleep_ack, st_reg.sleep_req,
					st_reg.soft_reset};                                        // [RULE18]
			end else if (acc_region && acc_ofs < `BUF_BYTES) begin
				st_next.rdata = st_reg.msg_mem[acc_buf][acc_ofs];                // [RULE2]
			end else if (acc_region && acc_ofs == `OFS_PRIORITY && acc_buf != `RX_BUF_INDEX) begin
				st_next.rdata = st_reg.prio[acc_buf - 2'h1];                     // [RULE13]
			end
		end

		// Control register: only the soft-reset bit is taken while in soft reset
		if (reg_wr_in && reg_addr_in == `CTRL0_ADDR) begin
			st_next.soft_reset = reg_wdata_in[`SOFT_RESET_BIT];
			if (!st_reg.soft_reset) begin
				st_next.wait_stop  = reg_wdata_in[`WAIT_STOP_BIT];
				st_next.timer_link = reg_wdata_in[`TIMER_LINK_BIT];
				st_next.sleep_req  = reg_wdata_in[`SLEEP_REQ_BIT];
			end
		end

		// Receive buffer ignores writes; transmit buffers always writable
		if (reg_wr_in && acc_region && acc_buf != `RX_BUF_INDEX) begin
			if (acc_ofs < `BUF_BYTES) begin
				st_next.msg_mem[acc_buf][acc_ofs] = reg_wdata_in;                // [RULE2]
			end else if (acc_ofs == `OFS_PRIORITY) begin
				st_next.prio[acc_buf - 2'h1] = reg_wdata_in;                     // [RULE13]
			end
		end

		// Queue clears first so a same-cycle completion still sets the flag
		st_next.tx_empty = st_reg.tx_empty & ~tx_queue_in;                         // [RULE25]
		if (rx_release_in) begin
			st_next.rx_full = 1'b0;
		end

		if (st_reg.tx_valid && tx_done_in) begin
			st_next.tx_empty[st_reg.tx_sel] = 1'b1;                                // [RULE25]
			st_next.tx_valid = 1'b0;
		end

		// Latch the winning frame at start of frame so later edits cannot tear it
		if (tx_sof_req_in && !st_reg.tx_valid && winner[2]) begin                  // [RULE14]
			st_next.tx_valid = 1'b1;
			st_next.tx_sel   = winner[1:0];
			st_next.tx_ext   = st_reg.msg_mem[winner[1:0] + 2'h1][`OFS_ID_BYTE1][`ID1_EXT_BIT];
			st_next.tx_id    = id_decode(st_reg.msg_mem[winner[1:0] + 2'h1][3:0],
				st_next.tx_ext);                                               // [RULE8]
			st_next.tx_srr   = st_reg.msg_mem[winner[1:0] + 2'h1][`OFS_ID_BYTE1][`ID1_SRR_BIT];
			st_next.tx_rtr   = st_next.tx_ext
				? st_reg.msg_mem[winner[1:0] + 2'h1][`OFS_ID_BYTE3][`ID3_EXT_RTR_BIT]
				: st_reg.msg_mem[winner[1:0] + 2'h1][`OFS_ID_BYTE1][`ID1_STD_RTR_BIT]; // [RULE9]
			st_next.tx_dlc   = st_reg.msg_mem[winner[1:0] + 2'h1][`OFS_LENGTH][3:0];   // [RULE10]
			st_next.tx_count = byte_count(st_next.tx_dlc, st_next.tx_rtr);
			for (int k = 0; k < 8; k++) begin
				st_next.tx_data[k] = (k < st_next.tx_count)
					? st_reg.msg_mem[winner[1:0] + 2'h1][4 + k] : 8'h00;       // [RULE12]
			end
		end

		// Received frame lands in the foreground buffer in the matching layout
		if (rx_store_in && !st_reg.soft_reset) begin
			if (rx_ext_in) begin
				st_next.msg_mem[0][`OFS_ID_BYTE0] = rx_id_in[28:21];             // [RULE3]
				st_next.msg_mem[0][`OFS_ID_BYTE1] = {rx_id_in[20:18], rx_srr_in, 1'b1,
					rx_id_in[17:15]};                                          // [RULE7]
				st_next.msg_mem[0][`OFS_ID_BYTE2] = rx_id_in[14:7];
				st_next.msg_mem[0][`OFS_ID_BYTE3] = {rx_id_in[6:0], rx_rtr_in};   // [RULE9]
			end else begin
				st_next.msg_mem[0][`OFS_ID_BYTE0] = rx_id_in[10:3];              // [RULE4]
				st_next.msg_mem[0][`OFS_ID_BYTE1] = {rx_id_in[2:0], rx_rtr_in, 1'b0, 3'b000};
			end
			st_next.msg_mem[0][`OFS_LENGTH] = {4'h0, rx_length_code_in};           // [RULE11]
			for (int k = 0; k < 8; k++) begin
				if (k < rx_count) begin
					st_next.msg_mem[0][4 + k] = rx_data_in[k];               // [RULE12]
				end
			end
			st_next.rx_full = 1'b1;
		end

		// Bus integration after soft reset is released
		unique case (st_reg.sync)
			msg_store_pkg::SYNC_OFF: begin
				st_next.rec_cnt = 4'h0;
				st_next.seq_cnt = 8'h00;
				if (!st_reg.soft_reset) begin
					st_next.sync = msg_store_pkg::SYNC_HUNT;
				end
			end
			msg_store_pkg::SYNC_HUNT: begin
				if (bit_tick_in && !bus_recessive_in) begin
					st_next.rec_cnt = 4'h0;
				end else if (bit_tick_in) begin
					st_next.rec_cnt = st_reg.rec_cnt + 4'h1;
					if (st_reg.rec_cnt + 4'h1 == `SYNC_RECESSIVE_BITS) begin     // [RULE22]
						st_next.rec_cnt = 4'h0;
						st_next.seq_cnt = st_reg.seq_cnt + 8'h01;
						if (!bus_off_in || st_reg.seq_cnt + 8'h01 == `BUSOFF_SEQUENCES) begin
							st_next.sync = msg_store_pkg::SYNC_ON;           // [RULE24]
						end
					end
				end
			end
			msg_store_pkg::SYNC_ON: begin
				st_next.sync = msg_store_pkg::SYNC_ON;
			end
			default: begin
				st_next.sync = msg_store_pkg::SYNC_OFF;
			end
		endcase

		// Sleep only once no frame is pending on the bus
		st_next.sleep_ack = st_reg.sleep_req && !bus_active_in && !st_reg.tx_valid; // [RULE23]

		// Soft reset holds control and flags; buffer contents are kept
		if (st_reg.soft_reset) begin                                               // [RULE21]
			st_next.wait_stop  = 1'(`CTRL0_RESET >> `WAIT_STOP_BIT);
			st_next.timer_link = 1'b0;
			st_next.sleep_req  = 1'b0;
			st_next.sleep_ack  = 1'b0;
			st_next.tx_empty   = 3'b111;
			st_next.rx_full    = 1'b0;
			st_next.tx_valid   = 1'b0;
			st_next.sync       = msg_store_pkg::SYNC_OFF;
		end
	end

	// Buffers also reset to zero here, but nothing may rely on it
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_reg            <= '0;                                                // [RULE1]
			st_reg.wait_stop  <= 1'b1;
			st_reg.soft_reset <= 1'b1;
			st_reg.tx_empty   <= 3'b111;
			st_reg.sync       <= msg_store_pkg::SYNC_OFF;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata_out         = st_reg.rdata;
	assign tx_empty_flag_out     = st_reg.tx_empty;
	assign rx_full_flag_out      = st_reg.rx_full;
	assign tx_valid_out          = st_reg.tx_valid;
	assign tx_buffer_sel_out     = st_reg.tx_sel;
	// Right-aligned so the bus engine can compare identifiers as plain numbers
	assign tx_id_out             = st_reg.tx_id;                                     // [RULE5] [RULE6]
	assign tx_ext_out            = st_reg.tx_ext;
	assign tx_srr_out            = st_reg.tx_srr;
	assign tx_rtr_out            = st_reg.tx_rtr;
	assign tx_length_code_out    = st_reg.tx_dlc;
	assign tx_byte_count_out     = st_reg.tx_count;
	assign tx_data_out           = st_reg.tx_data;
	// Gating is done by the clock controller; module can only request it
	assign module_clock_run_out  = !(st_reg.wait_stop && wait_mode_in);               // [RULE19]
	assign timer_link_out        = st_reg.timer_link;
	assign soft_reset_out        = st_reg.soft_reset;                                // [RULE21]
	assign bus_synced_status_out = st_reg.sync == msg_store_pkg::SYNC_ON;            // [RULE24]
	assign sleep_acknowledge_out = st_reg.sleep_ack;

	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!arst_n_in);

	ctrl_reserved_a: assert property (reg_rd_in && reg_addr_in == `CTRL0_ADDR
		|=> reg_rdata_out[7:6] == 2'b00 && reg_rdata_out[0] == $past(st_reg.soft_reset)) // [RULE18]
		else $error("control register reads wrong");

	soft_hold_a: assert property (st_reg.soft_reset
		|=> tx_empty_flag_out == 3'b111 && !rx_full_flag_out && !tx_valid_out
		&& !bus_synced_status_out) // [RULE21]
		else $error("soft reset does not hold flags");

	rx_readonly_a: assert property (reg_wr_in && acc_region && acc_buf == `RX_BUF_INDEX
		&& !rx_store_in |=> $stable(st_reg.msg_mem[0])) // [RULE2]
		else $error("receive buffer was written");

	arb_pick_a: assert property (tx_sof_req_in && !tx_valid_out && !soft_reset_out
		&& tx_empty_flag_out != 3'b111
		|=> tx_valid_out
		&& pick_winner($past(st_reg.prio), $past(st_reg.tx_empty))
		== {1'b1, tx_buffer_sel_out}) // [RULE15]
		else $error("wrong transmit buffer chosen");

	remote_nodata_a: assert property (tx_valid_out && tx_rtr_out
		|-> tx_byte_count_out == 4'h0 && tx_data_out == 64'h0000_0000_0000_0000) // [RULE10]
		else $error("remote frame carries data");

	count_cap_a: assert property (tx_valid_out && tx_length_code_out > 4'h8 && !tx_rtr_out
		|-> tx_byte_count_out == 4'h8) // [RULE26]
		else $error("length code above eight not capped");

	std_layout_a: assert property (tx_valid_out && !tx_ext_out
		|-> tx_id_out[28:11] == 18'h0_0000) // [RULE4]
		else $error("standard identifier too wide");

	done_sets_a: assert property (tx_done_in && tx_valid_out
		|=> !tx_valid_out && tx_empty_flag_out[$past(tx_buffer_sel_out)]) // [RULE25]
		else $error("sent buffer not marked empty");

	rx_store_a: assert property (rx_store_in && !soft_reset_out
		|=> rx_full_flag_out
		&& st_reg.msg_mem[0][`OFS_ID_BYTE1][`ID1_EXT_BIT] == $past(rx_ext_in)) // [RULE8]
		else $error("received frame not stored");

	sleep_hand_a: assert property (sleep_acknowledge_out |-> $past(st_reg.sleep_req)) // [RULE23]
		else $error("sleep acknowledged without request");

	sync_wait_a: assert property ($fell(soft_reset_out) |-> !bus_synced_status_out[*3]) // [RULE22]
		else $error("synchronised too early");

endmodule

// ---- src/msg_store_regs.svh ----
`ifndef MSG_STORE_REGS_SVH
`define MSG_STORE_REGS_SVH

// Register map
`define CTRL0_ADDR          9'h100
`define BUF_REGION          3'h5
`define RX_BUF_INDEX        2'h0
`define OFS_ID_BYTE0        4'h0
`define OFS_ID_BYTE1        4'h1
`define OFS_ID_BYTE2        4'h2
`define OFS_ID_BYTE3        4'h3
`define OFS_PAYLOAD0        4'h4
`define OFS_LENGTH          4'hC
`define OFS_PRIORITY        4'hD
`define BUF_BYTES           4'hD

// Control register 0 fields and reset value
`define CTRL0_RESET         8'h21
`define WAIT_STOP_BIT       5
`define SYNCED_BIT          4
`define TIMER_LINK_BIT      3
`define SLEEP_ACK_BIT       2
`define SLEEP_REQ_BIT       1
`define SOFT_RESET_BIT      0

// Identifier byte 1 and 3 field positions
`define ID1_SRR_BIT         4
`define ID1_EXT_BIT         3
`define ID1_STD_RTR_BIT     4
`define ID3_EXT_RTR_BIT     0

// Frame limits and synchronisation counts
`define MAX_DATA_BYTES      4'h8
`define SYNC_RECESSIVE_BITS 4'hB
`define BUSOFF_SEQUENCES    8'h80

`endif

// ---- src/msg_store_pkg.sv ----
package msg_store_pkg;

	typedef enum logic [1:0] {
		SYNC_OFF  = 2'b00,
		SYNC_HUNT = 2'b01,
		SYNC_ON   = 2'b11
	} sync_state_t;

	typedef struct packed {
		logic [3:0][12:0][7:0] msg_mem;
		logic [2:0][7:0]       prio;
		logic                  wait_stop;
		logic                  timer_link;
		logic                  sleep_req;
		logic                  sleep_ack;
		logic                  soft_reset;
		sync_state_t           sync;
		logic [3:0]            rec_cnt;
		logic [7:0]            seq_cnt;
		logic [2:0]            tx_empty;
		logic                  rx_full;
		logic                  tx_valid;
		logic [1:0]            tx_sel;
		logic [28:0]           tx_id;
		logic                  tx_ext;
		logic                  tx_srr;
		logic                  tx_rtr;
		logic [3:0]            tx_dlc;
		logic [3:0]            tx_count;
		logic [7:0][7:0]       tx_data;
		logic [7:0]            rdata;
	} state_t;

endpackage

// ---- verification/can_bus_partner.sv ----
`timescale 1ns/1ps
module can_bus_partner (
	output logic                 sof_req_out,
	output logic                 done_out,
	output logic                 store_out,
	output logic      [28:0]     id_out,
	output logic                 ext_out,
	output logic                 srr_out,
	output logic                 rtr_out,
	output logic      [3:0]      length_code_out,
	output logic      [7:0][7:0] data_out,
	output logic                 tick_out,
	output logic                 recessive_out,
	input  wire logic            clock_in
);
	initial begin
		sof_req_out   = 1'h0;
		done_out      = 1'h0;
		store_out     = 1'h0;
		{id_out, ext_out, srr_out, rtr_out, length_code_out, data_out} = '0;
		tick_out      = 1'h0;
		recessive_out = 1'h1;
	end
	// Level between ticks is not sampled, so show the opposite to expose stale use
	task automatic bits(input int n, input logic lvl);
		repeat (n) begin
			@(posedge clock_in);
			tick_out      <= 1'h1;
			recessive_out <= lvl;
			@(posedge clock_in);
			tick_out      <= 1'h0;
			recessive_out <= ~lvl;
		end
	endtask
	task automatic pulse_sof();
		@(posedge clock_in);
		sof_req_out <= 1'h1;
		@(posedge clock_in);
		sof_req_out <= 1'h0;
	endtask
	// Delay stands for frame length on the wire, so both quick and slow answers occur
	task automatic pulse_done(input int delay);
		repeat (delay) @(posedge clock_in);
		done_out <= 1'h1;
		@(posedge clock_in);
		done_out <= 1'h0;
	endtask
	task automatic deliver(input logic [28:0] id, input logic ext, substitute_remote_bit, remote_frame_flag,
			input logic [3:0] dlc, input logic [63:0] data);
		@(posedge clock_in);
		store_out       <= 1'h1;
		id_out          <= id;
		ext_out         <= ext;
		srr_out         <= substitute_remote_bit;
		rtr_out         <= remote_frame_flag;
		length_code_out <= dlc;
		data_out        <= data;
		@(posedge clock_in);
		store_out <= 1'h0;
		{id_out, ext_out, srr_out, rtr_out, length_code_out, data_out} <=
			~{id, ext, substitute_remote_bit, remote_frame_flag, dlc, data};
	endtask
endmodule

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	logic            clock_in, arst_n_in, reg_wr_in, reg_rd_in, rx_release_in, rx_full_flag_out;
	logic            tx_sof_req_in, tx_done_in, tx_valid_out, tx_ext_out, tx_srr_out, tx_rtr_out;
	logic            rx_store_in, rx_ext_in, rx_srr_in, rx_rtr_in, bit_tick_in, bus_recessive_in;
	logic            bus_off_in, bus_active_in, wait_mode_in, module_clock_run_out;
	logic            timer_link_out, soft_reset_out, bus_synced_status_out, sleep_acknowledge_out;
	logic [1:0]      tx_buffer_sel_out;
	logic [2:0]      tx_queue_in, tx_empty_flag_out;
	logic [3:0]      tx_length_code_out, tx_byte_count_out, rx_length_code_in;
	logic [7:0]      reg_wdata_in, reg_rdata_out;
	logic [8:0]      reg_addr_in;
	logic [28:0]     tx_id_out, rx_id_in;
	logic [7:0][7:0] tx_data_out, rx_data_in;
	int              n_errors = 0;
	int              samples_checked = 0;

	can_message_buffer_store can_message_buffer_store_inst (.clock_in, .arst_n_in, .reg_addr_in,
		.reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .tx_queue_in, .tx_empty_flag_out,
		.rx_release_in, .rx_full_flag_out, .tx_sof_req_in, .tx_done_in, .tx_valid_out,
		.tx_buffer_sel_out, .tx_id_out, .tx_ext_out, .tx_srr_out, .tx_rtr_out, .tx_length_code_out,
		.tx_byte_count_out, .tx_data_out, .rx_store_in, .rx_id_in, .rx_ext_in, .rx_srr_in,
		.rx_rtr_in, .rx_length_code_in, .rx_data_in, .bit_tick_in, .bus_recessive_in, .bus_off_in,
		.bus_active_in, .wait_mode_in, .module_clock_run_out, .timer_link_out, .soft_reset_out,
		.bus_synced_status_out, .sleep_acknowledge_out);
	can_bus_partner partner_inst (.clock_in, .sof_req_out(tx_sof_req_in), .done_out(tx_done_in),
		.store_out(rx_store_in), .id_out(rx_id_in), .ext_out(rx_ext_in), .srr_out(rx_srr_in),
		.rtr_out(rx_rtr_in), .length_code_out(rx_length_code_in), .data_out(rx_data_in),
		.tick_out(bit_tick_in), .recessive_out(bus_recessive_in));

	initial clock_in = 1'h0;
	always #10 clock_in = ~clock_in;

	task automatic results();
		$display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic flag(input int s);
		case (s)
			0: return tx_valid_out;
			1: return rx_full_flag_out;
			2: return bus_synced_status_out;
			default: return sleep_acknowledge_out;
		endcase
	endfunction
	task automatic wait_for(input int s);
		for (int i = 0; i < 20 && flag(s) !== 1'h1; i++) @(posedge clock_in);
		#1 check(64'(flag(s)), 64'h1);
		if (flag(s) !== 1'h1) results();
	endtask
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge clock_in);
		reg_wr_in    <= 1'h1;
		reg_addr_in  <= a;
		reg_wdata_in <= d;
		@(posedge clock_in);
		reg_wr_in <= 1'h0;
	endtask
	task automatic rdc(input logic [8:0] a, input logic [7:0] exp);
		@(posedge clock_in);
		reg_rd_in   <= 1'h1;
		reg_addr_in <= a;
		@(posedge clock_in);
		reg_rd_in <= 1'h0;
		#1 check(64'(reg_rdata_out), 64'(exp));
	endtask
	function automatic logic [31:0] id_bytes(input logic [28:0] id, input logic ext, remote_frame_flag);
		if (ext) return {id[28:21], id[20:18], 2'h3, id[17:15], id[14:7], id[6:0], remote_frame_flag};
		return {id[10:3], id[2:0], remote_frame_flag, 1'h0, 3'h0, 16'h0000};
	endfunction
	task automatic load(input int b, input logic [28:0] id, input logic ext, remote_frame_flag,
			input logic [7:0] dlc, prio);
		logic [31:0] ib;
		logic [8:0]  base;
		ib   = id_bytes(id, ext, remote_frame_flag);
		base = 9'h150 + 9'(b * 16);
		for (int k = 0; k < 4; k++) wr(base + 9'(k), ib[31 - 8 * k -: 8]);
		for (int k = 0; k < 8; k++) wr(base + 9'(4 + k), 8'(128 + b * 16 + k));
		wr(base + 9'h00C, dlc);
		wr(base + 9'h00D, prio);
	endtask
	task automatic send(input int b, input logic [28:0] id, input logic ext, remote_frame_flag,
			input logic [3:0] dlc, input int slow);
		logic [3:0]  cnt;
		logic [31:0] got;
		logic [63:0] dat;
		cnt = remote_frame_flag ? 4'h0 : (dlc > 4'h8 ? 4'h8 : dlc);
		dat = '0;
		for (int k = 0; k < 8; k++) if (k < cnt) dat[8 * k +: 8] = 8'(128 + b * 16 + k);
		partner_inst.pulse_sof();
		wait_for(0);
		got = {tx_ext_out, ext & tx_srr_out, tx_rtr_out, tx_id_out};
		check(64'(tx_buffer_sel_out), 64'(b));
		check(64'(got), 64'({ext, ext, remote_frame_flag, id}));
		check(64'(tx_length_code_out), 64'(dlc));
		check(64'(tx_byte_count_out), 64'(cnt));
		check(tx_data_out, dat);
		partner_inst.pulse_done(slow);
		#1 check(64'({tx_valid_out, tx_empty_flag_out[b]}), 64'h1);
	endtask
	task automatic rx_frame(input logic [28:0] id, input logic ext, remote_frame_flag, input logic [3:0] dlc,
			input logic [63:0] data);
		logic [31:0] ib;
		ib = id_bytes(id, ext, remote_frame_flag);
		partner_inst.deliver(id, ext, ext, remote_frame_flag, dlc, data);
		wait_for(1);
		for (int k = 0; k < (ext ? 4 : 2); k++)
			rdc(9'h140 + 9'(k), ib[31 - 8 * k -: 8]);
		rdc(9'h14C, 8'(dlc));
		if (!remote_frame_flag) rdc(9'h145, data[15:8]);
	endtask

	initial begin
		arst_n_in     = 1'h0;
		reg_addr_in   = 9'h000;
		reg_wr_in     = 1'h0;
		reg_rd_in     = 1'h0;
		reg_wdata_in  = 8'h00;
		tx_queue_in   = 3'h0;
		rx_release_in = 1'h0;
		bus_off_in    = 1'h0;
		bus_active_in = 1'h0;
		wait_mode_in  = 1'h1;
		repeat (10) @(posedge clock_in);
		arst_n_in <= 1'h1;
		#1 check(64'({soft_reset_out, tx_empty_flag_out, module_clock_run_out}), 64'h1E);
		rdc(9'h100, 8'h21);
		wr(9'h100, 8'h00);
		wr(9'h100, 8'hC8);
		#1 check(64'({module_clock_run_out, timer_link_out}), 64'h3);
		rdc(9'h100, 8'h08);
		partner_inst.bits(10, 1'h1);
		partner_inst.bits(1, 1'h0);
		partner_inst.bits(10, 1'h1);
		repeat (3) @(posedge clock_in);
		#1 check(64'(bus_synced_status_out), 64'h0);
		partner_inst.bits(1, 1'h1);
		wait_for(2);
		rdc(9'h100, 8'h18);
		partner_inst.pulse_sof();
		repeat (2) @(posedge clock_in);
		#1 check(64'(tx_valid_out), 64'h0);
		load(0, 29'h0000_05A3, 1'h0, 1'h1, 8'h05, 8'h05);
		load(1, 29'h0ABC_DE12, 1'h1, 1'h0, 8'h03, 8'h03);
		load(2, 29'h1555_AAA5, 1'h1, 1'h0, 8'h0C, 8'h03);
		rdc(9'h15D, 8'h05);
		rdc(9'h164, 8'h90);
		wr(9'h176, 8'h00);
		rdc(9'h176, 8'h00);
		wr(9'h176, 8'hA2);
		wr(9'h100, 8'h08);
		tx_queue_in <= 3'h7;
		@(posedge clock_in);
		tx_queue_in <= 3'h0;
		#1 check(64'(tx_empty_flag_out), 64'h0);
		send(1, 29'h0ABC_DE12, 1'h1, 1'h0, 4'h3, 1);
		send(2, 29'h1555_AAA5, 1'h1, 1'h0, 4'hC, 40);
		send(0, 29'h0000_05A3, 1'h0, 1'h1, 4'h5, 3);
		wr(9'h100, 8'h0A);
		wait_for(3);
		wr(9'h100, 8'h08);
		repeat (3) @(posedge clock_in);
		#1 check(64'(sleep_acknowledge_out), 64'h0);
		rx_frame(29'h1234_5679, 1'h1, 1'h0, 4'h2, 64'h1122_3344_5566_7788);
		wr(9'h140, 8'h00);
		rdc(9'h140, 8'h91);
		rdc(9'h14D, 8'h00);
		rdc(9'h14E, 8'h00);
		rx_release_in <= 1'h1;
		@(posedge clock_in);
		rx_release_in <= 1'h0;
		#1 check(64'(rx_full_flag_out), 64'h0);
		rx_frame(29'h0000_0123, 1'h0, 1'h1, 4'h4, 64'h0102_0304_0506_0708);
		tx_queue_in <= 3'h1;
		@(posedge clock_in);
		tx_queue_in <= 3'h0;
		partner_inst.pulse_sof();
		wait_for(0);
		wr(9'h100, 8'h09);
		repeat (2) @(posedge clock_in);
		#1 check(64'({tx_valid_out, tx_empty_flag_out, bus_synced_status_out}), 64'h0E);
		rdc(9'h100, 8'h21);
		bus_off_in <= 1'h1;
		wr(9'h100, 8'h00);
		partner_inst.bits(1407, 1'h1);
		repeat (3) @(posedge clock_in);
		#1 check(64'(bus_synced_status_out), 64'h0);
		partner_inst.bits(1, 1'h1);
		wait_for(2);
		results();
	end
endmodule
